// >>> rtl/i2cm_defs.svh
// constants shared by both ends of the mux command link
`ifndef I2CM_DEFS_SVH
`define I2CM_DEFS_SVH

// target address: fixed upper bits, lower three bits come from address pins
`define I2CM_ADDR_BASE    4'h9
`define I2CM_ADDR_RST     7'h48

// command byte field positions
`define I2CM_BIT_LEVEL    7
`define I2CM_BIT_SRSTN    6
`define I2CM_BIT_LOAD     5
`define I2CM_SEL_HI       4

// selector codes
`define I2CM_SEL_MUX_DIS  5'h10
`define I2CM_SEL_OUT1     5'h13
`define I2CM_SEL_OUT2     5'h14
`define I2CM_SEL_OUTB     5'h15
`define I2CM_SEL_ALL      5'h1f

// reset values of the switch and output state
`define I2CM_SW_RST       9'h000
`define I2CM_OUT_RST      2'h0

// controller register offsets and status fields
`define I2CM_REG_TARGET   8'h00
`define I2CM_REG_DATA0    8'h04
`define I2CM_REG_CMD      8'h08
`define I2CM_REG_READ     8'h0c
`define I2CM_REG_STAT     8'h10
`define I2CM_STAT_BUSY    0
`define I2CM_STAT_NACK    1

// timing: serial clock period and the controller clock period in ns
`define I2CM_MCLK_NS      100
`define I2CM_SCL_NS       10000
`define I2CM_QUARTER      ((`I2CM_SCL_NS + 4 * `I2CM_MCLK_NS - 1) / (4 * `I2CM_MCLK_NS))

`endif

// >>> rtl/i2cm_pkg.sv
// types shared by both ends of the mux command link
package i2cm_pkg;

    // target protocol states
    typedef enum logic [6:0] {
        TGT_IDLE = 7'b000_0001,
        TGT_ADDR = 7'b000_0010,
        TGT_ACKA = 7'b000_0100,
        TGT_WRIT = 7'b000_1000,
        TGT_ACKW = 7'b001_0000,
        TGT_READ = 7'b010_0000,
        TGT_MACK = 7'b100_0000
    } i2cm_tgt_e;

    // controller engine states
    typedef enum logic [3:0] {
        CTL_IDLE  = 4'b0001,
        CTL_START = 4'b0010,
        CTL_BITS  = 4'b0100,
        CTL_STOP  = 4'b1000
    } i2cm_ctl_e;

endpackage

// >>> rtl/i2cm_if.sv
// two-wire link between the mux controller and the mux target
`timescale 1ns/1ps
interface i2cm_if;
    logic scl;        // serial clock, driven by the controller
    logic sdaHostO;   // controller data output value
    logic sdaHostOe;  // controller pulls data line
    logic sdaDevO;    // target data output value
    logic sdaDevOe;   // target pulls data line
    logic sda;        // resolved data line, pulled up when nobody drives

    // wired-and with pull-up
    assign sda = (~sdaHostOe | sdaHostO) & (~sdaDevOe | sdaDevO);

    modport host (output scl, output sdaHostO, output sdaHostOe, input sda);
    modport dev  (input scl, output sdaDevO, output sdaDevOe, input sda);
endinterface

// >>> rtl/i2cm_target.sv
// mux target end: serial command decode, staged switch update, status readback
`timescale 1ns/1ps
`include "i2cm_defs.svh"
module i2cm_target
    import i2cm_pkg::*;
#(
    parameter bit hasOutputs = 1'b1  // variant with the two general outputs
) (
    input  wire logic   linkClk,
    input  wire logic   nrst,
    input  wire logic [2:0] addrPins,
    i2cm_if.dev         bus,
    output logic [8:0]  switchState,
    output logic        generalOutputOne,
    output logic        generalOutputTwo
);

    // state word layout: {mux1 a,b,c, mux2 a,b,c, mux3 a,b,c, out1, out2}
    function automatic logic [10:0] applyCmd(input logic [10:0] cur,
                                             input logic [7:0]  cmd);
        logic [10:0] nxt;
        logic [4:0]  sel;
        logic        lvl;
        nxt = cur;
        sel = cmd[`I2CM_SEL_HI:0];
        lvl = cmd[`I2CM_BIT_LEVEL];
        for (int m = 0; m < 3; m++) begin
            // single switch on or off, input index 3 is reserved
            for (int i = 0; i < 3; i++) begin
                if (sel == {1'b0, 2'(m + 1), 2'(i)}) begin
                    nxt[10 - 3 * m - i] = lvl;
                end
            end
            if (sel == 5'(`I2CM_SEL_MUX_DIS + m)) begin
                nxt[10 - 3 * m -: 3] = 3'h0;
            end
        end
        if (hasOutputs) begin
            if (sel == `I2CM_SEL_OUT1 || sel == `I2CM_SEL_OUTB) begin
                nxt[1] = lvl;
            end
            if (sel == `I2CM_SEL_OUT2 || sel == `I2CM_SEL_OUTB) begin
                nxt[0] = lvl;
            end
        end
        if (sel == `I2CM_SEL_ALL && !lvl) begin
            nxt[10:2] = 9'h000;
        end
        return nxt;
    endfunction

    // three-stage pin synchronisers and agreement filters
    logic [2:0]  sclSync;     // [0] first stage, read only by [1]
    logic [2:0]  sdaSync;
    logic        sclF_r;      // filtered clock level
    logic        sdaF_r;      // filtered data level
    logic        sclP_r;      // filtered levels one cycle back
    logic        sdaP_r;

    // protocol state
    i2cm_tgt_e   state_r;
    logic [3:0]  bitCnt_r;    // bits clocked in the current byte
    logic [1:0]  byteCnt_r;   // data bytes seen in this transfer
    logic [7:0]  shift_r;     // receive shifter
    logic [15:0] txWord_r;    // status word, msb is the bit on the wire
    logic        rw_r;        // read requested
    logic        mAck_r;      // controller acked the last status byte
    logic        sdaOe_r;     // pulling the data line low
    logic [7:0]  cmdByte_r;   // last complete command byte
    logic        cmdStrobe_r; // one-cycle pulse, command byte complete

    // applied and staged switch/output state
    logic [10:0] live_r;
    logic [10:0] pend_r;
    logic [10:0] pend_nxt;
    logic [15:0] statusWord;

    // bus events on the filtered levels
    logic        startEv;
    logic        stopEv;
    logic        sclRise;
    logic        sclFall;

    assign startEv = sclF_r & sclP_r & sdaP_r & ~sdaF_r;
    assign stopEv  = sclF_r & sclP_r & ~sdaP_r & sdaF_r;
    assign sclRise = sclF_r & ~sclP_r;
    assign sclFall = ~sclF_r & sclP_r;

    // synchronise the pins; a level counts once stages two and three agree
    always_ff @(posedge linkClk or negedge nrst) begin
        if (!nrst) begin
            sclSync <= 3'h7;
            sdaSync <= 3'h7;
            sclF_r  <= 1'b1;
            sdaF_r  <= 1'b1;
            sclP_r  <= 1'b1;
            sdaP_r  <= 1'b1;
        end else begin
            sclSync <= {sclSync[1:0], bus.scl};
            sdaSync <= {sdaSync[1:0], bus.sda};
            if (sclSync[1] == sclSync[2]) begin
                sclF_r <= sclSync[2];
            end
            if (sdaSync[1] == sdaSync[2]) begin
                sdaF_r <= sdaSync[2];
            end
            sclP_r <= sclF_r;
            sdaP_r <= sdaF_r;
        end
    end

    assign statusWord = {live_r[10:8], 1'b0, live_r[7:5], 1'b0, live_r[4:2], 1'b0,
                         hasOutputs & live_r[1], hasOutputs & live_r[0], 2'b00};

    // serial protocol; the data line only changes after the clock has fallen
    always_ff @(posedge linkClk or negedge nrst) begin
        if (!nrst) begin
            state_r     <= TGT_IDLE;
            bitCnt_r    <= 4'h0;
            byteCnt_r   <= 2'h0;
            shift_r     <= 8'h00;
            txWord_r    <= 16'h0000;
            rw_r        <= 1'b0;
            mAck_r      <= 1'b0;
            sdaOe_r     <= 1'b0;
            cmdByte_r   <= 8'h00;
            cmdStrobe_r <= 1'b0;
        end else begin
            cmdStrobe_r <= 1'b0;
            if (startEv) begin
                // a start, repeated or not, always restarts the address phase
                state_r   <= TGT_ADDR;
                bitCnt_r  <= 4'h0;
                byteCnt_r <= 2'h0;
                sdaOe_r   <= 1'b0;
            end else if (stopEv) begin
                state_r <= TGT_IDLE;
                sdaOe_r <= 1'b0;
            end else begin
                unique case (state_r)
                    TGT_IDLE: begin
                        sdaOe_r <= 1'b0;
                    end
                    TGT_ADDR: begin
                        if (sclRise) begin
                            shift_r  <= {shift_r[6:0], sdaF_r};
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end else if (sclFall && bitCnt_r == 4'h8) begin
                            if (shift_r[7:1] == {`I2CM_ADDR_BASE, addrPins}) begin
                                sdaOe_r <= 1'b1;
                                rw_r    <= shift_r[0];
                                state_r <= TGT_ACKA;
                            end else begin
                                state_r <= TGT_IDLE;
                            end
                        end
                    end
                    TGT_ACKA: begin
                        if (sclFall) begin
                            bitCnt_r <= 4'h0;
                            if (rw_r) begin
                                txWord_r <= statusWord;
                                sdaOe_r  <= ~statusWord[15];
                                state_r  <= TGT_READ;
                            end else begin
                                sdaOe_r <= 1'b0;
                                state_r <= TGT_WRIT;
                            end
                        end
                    end
                    TGT_WRIT: begin
                        if (sclRise) begin
                            shift_r  <= {shift_r[6:0], sdaF_r};
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end else if (sclFall && bitCnt_r == 4'h8) begin
                            sdaOe_r <= 1'b1;
                            state_r <= TGT_ACKW;
                            if (byteCnt_r != 2'h3) begin
                                byteCnt_r <= byteCnt_r + 2'h1;
                            end
                            if (byteCnt_r == 2'h1) begin
                                cmdByte_r   <= shift_r;
                                cmdStrobe_r <= 1'b1;
                            end
                        end
                    end
                    TGT_ACKW: begin
                        if (sclFall) begin
                            sdaOe_r  <= 1'b0;
                            bitCnt_r <= 4'h0;
                            state_r  <= TGT_WRIT;
                        end
                    end
                    TGT_READ: begin
                        if (sclRise) begin
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end else if (sclFall) begin
                            if (bitCnt_r == 4'h8) begin
                                sdaOe_r <= 1'b0;
                                state_r <= TGT_MACK;
                            end else begin
                                txWord_r <= {txWord_r[14:0], 1'b0};
                                sdaOe_r  <= ~txWord_r[14];
                            end
                        end
                    end
                    TGT_MACK: begin
                        if (sclRise) begin
                            mAck_r <= ~sdaF_r;
                        end else if (sclFall) begin
                            bitCnt_r <= 4'h0;
                            if (mAck_r && byteCnt_r == 2'h0) begin
                                byteCnt_r <= 2'h1;
                                txWord_r  <= {txWord_r[14:0], 1'b0};
                                sdaOe_r   <= ~txWord_r[14];
                                state_r   <= TGT_READ;
                            end else begin
                                // a nack or the last byte ends the reply
                                sdaOe_r <= 1'b0;
                                state_r <= TGT_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // staged image of the next update
    assign pend_nxt = applyCmd(pend_r, cmdByte_r);

    // command execution: stage every command except a soft reset, which clears stage and live state; apply the stage on load
    always_ff @(posedge linkClk or negedge nrst) begin
        if (!nrst) begin
            live_r <= {`I2CM_SW_RST, `I2CM_OUT_RST};
            pend_r <= {`I2CM_SW_RST, `I2CM_OUT_RST};
        end else if (cmdStrobe_r) begin
            if (!cmdByte_r[`I2CM_BIT_SRSTN]) begin
                live_r <= {`I2CM_SW_RST, `I2CM_OUT_RST};
                pend_r <= {`I2CM_SW_RST, `I2CM_OUT_RST};
            end else begin
                pend_r <= pend_nxt;
                if (cmdByte_r[`I2CM_BIT_LOAD]) begin
                    live_r <= pend_nxt;
                end
            end
        end
    end

    // outputs from flip-flops, except the data output value, which is tied low
    assign switchState      = live_r[10:2];
    assign generalOutputOne = hasOutputs & live_r[1];
    assign generalOutputTwo = hasOutputs & live_r[0];
    assign bus.sdaDevO      = 1'b0;
    assign bus.sdaDevOe     = sdaOe_r;

endmodule

// >>> rtl/i2cm_controller.sv
// mux controller end: register port to serial write and read transfers
`timescale 1ns/1ps
`include "i2cm_defs.svh"
module i2cm_controller
    import i2cm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        nrst,
    i2cm_if.host             bus,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [15:0]      regRdata
);

    localparam logic [7:0] QTR_LAST = 8'(`I2CM_QUARTER - 1);

    i2cm_ctl_e   state_r;
    logic [7:0]  qCnt_r;      // mclk cycles within a quarter bit
    logic [1:0]  phase_r;     // quarter of the current bit
    logic [1:0]  byteIdx_r;   // 0 address, 1 and 2 data
    logic [3:0]  bitPos_r;    // 0..7 data bits, 8 ack slot
    logic        rw_r;        // current transfer is a read
    logic        ackBad_r;    // target did not ack
    logic        nack_r;      // last transfer ended on a nack
    logic [6:0]  target_r;
    logic [7:0]  data0_r;
    logic [7:0]  cmd_r;
    logic [15:0] rdStatus_r;
    logic [15:0] regRdata_r;
    logic        scl_r;
    logic        sdaOe_r;
    logic [2:0]  sdaSync;     // [0] first stage, read only by [1]
    logic        sdaF_r;
    logic        tick;
    logic        busy;
    logic        readSlot;    // target drives the data bits of this byte
    logic [7:0]  txByte;
    logic        drive0;      // want the data line low in this bit
    logic        goWr;
    logic        goRd;

    assign tick  = (qCnt_r == QTR_LAST);
    assign busy  = (state_r != CTL_IDLE);
    assign goWr  = regWr & ~busy & (regAddr == `I2CM_REG_CMD);
    assign goRd  = regWr & ~busy & (regAddr == `I2CM_REG_READ);
    assign readSlot = rw_r & (byteIdx_r != 2'h0);

    // byte on the wire and data line wish for the current bit
    always_comb begin
        unique case (byteIdx_r)
            2'h0:    txByte = {target_r, rw_r};
            2'h1:    txByte = data0_r;
            default: txByte = cmd_r;
        endcase
        if (bitPos_r < 4'h8) begin
            drive0 = ~readSlot & ~txByte[3'(4'h7 - bitPos_r)];
        end else begin
            // ack the first status byte, nack the last one
            drive0 = rw_r & (byteIdx_r == 2'h1);
        end
    end

    // data line synchroniser with agreement filter
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sdaSync <= 3'h7;
            sdaF_r  <= 1'b1;
        end else begin
            sdaSync <= {sdaSync[1:0], bus.sda};
            if (sdaSync[1] == sdaSync[2]) begin
                sdaF_r <= sdaSync[2];
            end
        end
    end

    // register writes; setup registers are locked while a transfer runs
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            target_r <= `I2CM_ADDR_RST;
            data0_r  <= 8'h00;
            cmd_r    <= 8'h00;
        end else if (regWr && !busy) begin
            if (regAddr == `I2CM_REG_TARGET) begin
                target_r <= regWdata[6:0];
            end
            if (regAddr == `I2CM_REG_DATA0) begin
                data0_r <= regWdata[7:0];
            end
            if (regAddr == `I2CM_REG_CMD) begin
                cmd_r <= regWdata[7:0];
            end
        end
    end

    // register reads: data valid in the next cycle only, unmapped reads zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            regRdata_r <= 16'h0000;
        end else if (regRd) begin
            unique case (regAddr)
                `I2CM_REG_TARGET: regRdata_r <= {9'h000, target_r};
                `I2CM_REG_DATA0:  regRdata_r <= {8'h00, data0_r};
                `I2CM_REG_CMD:    regRdata_r <= {8'h00, cmd_r};
                `I2CM_REG_READ:   regRdata_r <= rdStatus_r;
                `I2CM_REG_STAT:   regRdata_r <= {14'h0000, nack_r, busy};
                default:          regRdata_r <= 16'h0000;
            endcase
        end else begin
            regRdata_r <= 16'h0000;
        end
    end

    // serial engine: four quarters per bit, sample at the end of quarter two
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r    <= CTL_IDLE;
            qCnt_r     <= 8'h00;
            phase_r    <= 2'h0;
            byteIdx_r  <= 2'h0;
            bitPos_r   <= 4'h0;
            rw_r       <= 1'b0;
            ackBad_r   <= 1'b0;
            nack_r     <= 1'b0;
            rdStatus_r <= 16'h0000;
        end else if (!busy) begin
            qCnt_r <= 8'h00;
            if (goWr || goRd) begin
                rw_r      <= goRd;
                state_r   <= CTL_START;
                phase_r   <= 2'h0;
                byteIdx_r <= 2'h0;
                bitPos_r  <= 4'h0;
                ackBad_r  <= 1'b0;
                nack_r    <= 1'b0;
            end
        end else begin
            qCnt_r <= tick ? 8'h00 : qCnt_r + 8'h01;
            if (tick) begin
                phase_r <= phase_r + 2'h1;
                unique case (state_r)
                    CTL_START: begin
                        if (phase_r == 2'h1) begin
                            phase_r <= 2'h0;
                            state_r <= CTL_BITS;
                        end
                    end
                    CTL_BITS: begin
                        if (phase_r == 2'h2) begin
                            if (bitPos_r < 4'h8 && readSlot) begin
                                rdStatus_r <= {rdStatus_r[14:0], sdaF_r};
                            end
                            if (bitPos_r == 4'h8 && !readSlot) begin
                                ackBad_r <= sdaF_r;
                            end
                        end
                        if (phase_r == 2'h3) begin
                            if (bitPos_r != 4'h8) begin
                                bitPos_r <= bitPos_r + 4'h1;
                            end else if (ackBad_r || byteIdx_r == 2'h2) begin
                                nack_r  <= ackBad_r;
                                state_r <= CTL_STOP;
                            end else begin
                                byteIdx_r <= byteIdx_r + 2'h1;
                                bitPos_r  <= 4'h0;
                            end
                        end
                    end
                    CTL_STOP: begin
                        if (phase_r == 2'h3) begin
                            state_r <= CTL_IDLE;
                        end
                    end
                    default: state_r <= CTL_IDLE;
                endcase
            end
        end
    end

    // pin drivers, registered so the lines never glitch
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            scl_r   <= 1'b1;
            sdaOe_r <= 1'b0;
        end else begin
            unique case (state_r)
                CTL_START: begin
                    scl_r   <= 1'b1;
                    sdaOe_r <= (phase_r == 2'h1);
                end
                CTL_BITS: begin
                    scl_r   <= (phase_r == 2'h1) || (phase_r == 2'h2);
                    sdaOe_r <= drive0;
                end
                CTL_STOP: begin
                    scl_r   <= (phase_r != 2'h0);
                    sdaOe_r <= (phase_r < 2'h2);
                end
                default: begin
                    scl_r   <= 1'b1;
                    sdaOe_r <= 1'b0;
                end
            endcase
        end
    end

    assign bus.scl       = scl_r;
    assign bus.sdaHostO  = 1'b0;
    assign bus.sdaHostOe = sdaOe_r;
    assign regRdata      = regRdata_r;

endmodule

// >>> testbench/i2cm_properties.sv
// wire-level properties of the mux command link
`timescale 1ns/1ps
module i2cm_properties (
    input wire logic mclk,
    input wire logic linkClk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sdaHostO,
    input wire logic sdaHostOe,
    input wire logic sdaDevO,
    input wire logic sdaDevOe,
    input wire logic sda
);
    // both ends only ever pull low, never drive high
    property p_devOpenDrain; @(posedge linkClk) disable iff (!nrst) sdaDevOe |-> !sdaDevO; endproperty
    a_devOpenDrain: assert property (p_devOpenDrain) else $error("target drives high");
    property p_hostOpenDrain; @(posedge mclk) disable iff (!nrst) sdaHostOe |-> !sdaHostO; endproperty
    a_hostOpenDrain: assert property (p_hostOpenDrain) else $error("host drives high");
    property p_wireLevel; @(posedge mclk) disable iff (!nrst) sda == !(sdaHostOe || sdaDevOe); endproperty
    a_wireLevel: assert property (p_wireLevel) else $error("data line level wrong");
    // target data may only move while the clock is low
    property p_devStableHigh; @(posedge linkClk) disable iff (!nrst)
        scl && $past(scl) |-> $stable(sdaDevOe); endproperty
    a_devStableHigh: assert property (p_devStableHigh) else $error("target moved data");
    property p_devLag; @(posedge linkClk) disable iff (!nrst)
        $changed(sdaDevOe) |-> !scl && !$past(scl) && !$past(scl, 2); endproperty
    a_devLag: assert property (p_devLag) else $error("target changed too early");
    // clock low phase is one or two quarters, high phase at least eight cycles
    property p_sclLow; @(posedge mclk) disable iff (!nrst)
        $fell(scl) |-> !scl [*8] ##[17:47] scl; endproperty
    a_sclLow: assert property (p_sclLow) else $error("clock low phase length");
    property p_sclHigh; @(posedge mclk) disable iff (!nrst) $rose(scl) |-> scl [*8]; endproperty
    a_sclHigh: assert property (p_sclHigh) else $error("clock high phase short");
    // a fall of data under a high clock is a start and comes from the host
    property p_hostStart; @(posedge mclk) disable iff (!nrst)
        $fell(sda) && scl && $past(scl) |-> sdaHostOe; endproperty
    a_hostStart: assert property (p_hostStart) else $error("start not from host");
endmodule

// >>> testbench/i2c_mux_command_control_test.sv
// bench: controller and mux target joined over the two-wire link
`timescale 1ns/1ps
`include "i2cm_defs.svh"
module i2c_mux_command_control_test;
    import i2cm_pkg::*;
    logic        mclk = 0, linkClk = 0, nrst = 0, regWr = 0, regRd = 0, o1, o2;
    logic [7:0]  regAddr = 8'h00;
    logic [15:0] regWdata = 16'h0000, regRdata, rd;
    logic [8:0]  sw;
    int          err_count = 0, checked = 0, cyc = 0;
    // command, then switch and output state expected after it
    logic [18:0] codes [13] = '{{8'hE5, 9'h080, 2'h0}, {8'hEA, 9'h088, 2'h0},
        {8'hEC, 9'h08C, 2'h0}, {8'h71, 9'h084, 2'h0}, {8'hF2, 9'h080, 2'h0},
        {8'h70, 9'h000, 2'h0}, {8'hF3, 9'h000, 2'h2}, {8'hF4, 9'h000, 2'h3},
        {8'h75, 9'h000, 2'h0}, {8'hE4, 9'h100, 2'h0}, {8'hFF, 9'h100, 2'h0},
        {8'hE7, 9'h100, 2'h0}, {8'h7F, 9'h000, 2'h0}};
    i2cm_if u_i2cm_if ();
    i2cm_controller u_i2cm_controller (.mclk(mclk), .nrst(nrst), .bus(u_i2cm_if.host),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
    // address pins tied: target answers at base plus five
    i2cm_target u_i2cm_target (.linkClk(linkClk), .nrst(nrst), .addrPins(3'h5), .bus(u_i2cm_if.dev),
        .switchState(sw), .generalOutputOne(o1), .generalOutputTwo(o2));
    i2cm_properties u_i2cm_properties (.mclk(mclk), .linkClk(linkClk), .nrst(nrst),
        .scl(u_i2cm_if.scl), .sdaHostO(u_i2cm_if.sdaHostO), .sdaHostOe(u_i2cm_if.sdaHostOe),
        .sdaDevO(u_i2cm_if.sdaDevO), .sdaDevOe(u_i2cm_if.sdaDevOe), .sda(u_i2cm_if.sda));
    initial forever #50 mclk = ~mclk;
    // link clock offset so its edges never meet the register clock
    initial begin
        #7;
        forever #15 linkClk = ~linkClk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle register strobes, read data taken in the following cycle
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rdReg(input logic [7:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 rd = regRdata;
    endtask
    // bounded poll of the busy flag; the cycle ceiling catches a hang
    task automatic waitIdle;
        rdReg(`I2CM_REG_STAT);
        for (int i = 0; i < 3000 && rd[`I2CM_STAT_BUSY] !== 1'b0; i++) rdReg(`I2CM_REG_STAT);
    endtask
    task automatic send(input logic [7:0] c);
        wr(`I2CM_REG_CMD, {8'h00, c});
        waitIdle();
    endtask
    // live state at the pins, then the same state read back over the link
    task automatic verify(input logic [8:0] s, input logic [1:0] o);
        chk({5'h00, sw, o1, o2}, {5'h00, s, o});
        wr(`I2CM_REG_READ, 16'h0000);
        waitIdle();
        chk(rd & 16'h0003, 16'h0000);
        rdReg(`I2CM_REG_READ);
        chk(rd, {s[8:6], 1'b0, s[5:3], 1'b0, s[2:0], 1'b0, o, 2'h0});
    endtask
    // a foreign address is refused, then the power-up state reads back
    task automatic tAddr;
        wr(`I2CM_REG_READ, 16'h0000);
        waitIdle();
        chk(rd & 16'h0003, 16'h0002);
        wr(`I2CM_REG_TARGET, {9'h000, `I2CM_ADDR_BASE, 3'h5});
        verify(9'h000, 2'h0);
    endtask
    task automatic tStage;
        send(8'hC4);
        send(8'hC9);
        chk({7'h00, sw}, 16'h0000);
        send(8'hF3);
        verify(9'h110, 2'h2);
    endtask
    task automatic tCodes;
        // the table expects a cleared start, so drop what the staging test left
        send(8'h20);
        chk({5'h00, sw, o1, o2}, 16'h0000);
        foreach (codes[i]) begin
            send(codes[i][18:11]);
            chk({5'h00, sw, o1, o2}, {5'h00, codes[i][10:0]});
        end
    endtask
    // soft reset also drops a staged command
    task automatic tSoftReset;
        send(8'hF5);
        send(8'hC9);
        send(8'h24);
        verify(9'h000, 2'h0);
        send(8'hF3);
        chk({5'h00, sw, o1, o2}, 16'h0002);
    endtask
    task automatic conclude;
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        tAddr();
        tStage();
        tCodes();
        tSoftReset();
        conclude();
    end
endmodule
